// ---- verilog/acqctl_pkg.sv ----
// package: acquisition control constants and carrier types
package acqctl_pkg;

  // command codes of the decoded remote command strobe
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_ARM,
    CMD_STOP,
    CMD_SET_MODE,
    CMD_SET_AVG,
    CMD_SET_DEPTH,
    CMD_SET_INTERP,
    CMD_READ_STATUS
  } acqctl_cmd_t;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PEAK,
    MODE_AVERAGE,
    MODE_ENH_RES
  } acqctl_mode_t;

  typedef enum logic [1:0] {
    STATE_STOPPED,
    STATE_ARMED,
    STATE_TRIGGERED
  } acqctl_state_t;

  // status word bit positions
  localparam int unsigned STAT_NEW_ACQ_BIT = 0;
  localparam int unsigned STAT_TRIG_RDY_BIT = 13;
  localparam int unsigned STAT_W = 16;

  // averaging count is 2**avg_log2; legal log2 values 2 and 4..9
  localparam logic [3:0] AVG_LOG2_MIN = 4'h2;
  localparam logic [3:0] AVG_LOG2_MAX = 4'h9;
  localparam logic [3:0] AVG_LOG2_SKIP = 4'h3;
  localparam logic [3:0] AVG_LOG2_RST = 4'h4;

  // depth index 0..3: 7K,70K,700K,7M (or doubled when interleaved)
  localparam int unsigned DEPTH_W = 25;
  localparam logic [24:0] DEPTH_BASE_0 = 25'h0001b58;
  localparam logic [24:0] DEPTH_BASE_1 = 25'h0011170;
  localparam logic [24:0] DEPTH_BASE_2 = 25'h00aae60;
  localparam logic [24:0] DEPTH_BASE_3 = 25'h06acfc0;
  localparam logic [1:0] DEPTH_SEL_RST = 2'h0;

  localparam int unsigned CHAN_N = 4;
  localparam int unsigned PTS_W = 25;
  localparam int unsigned RATE_W = 32;
  localparam int unsigned SCALE_W = 25;

  // decoded command with its argument
  typedef struct packed {
    acqctl_cmd_t code;
    acqctl_mode_t mode;
    logic [3:0] avg_log2;
    logic [1:0] depth_sel;
    logic interp_sine;
  } acqctl_req_t;

  // answer of a command
  typedef struct packed {
    logic done;
    logic reject;
    logic [STAT_W-1:0] status;
  } acqctl_rsp_t;

  // settings reported back
  typedef struct packed {
    acqctl_mode_t mode;
    logic [3:0] avg_log2;
    logic [1:0] depth_sel;
    logic interp_sine;
    acqctl_state_t state;
  } acqctl_cfg_t;

endpackage : acqctl_pkg

// ---- verilog/acqctl_core.sv ----
// acquisition command control: arm/stop, status word, mode and depth settings
`timescale 1ns/1ps

// How it works
// R01: arm command re-arms the trigger and starts a new capture
// R02: status word has trigger-ready in bit 13, new-capture in bit 0
// R03: reading the status word returns it and clears it
// R04: in single trigger mode a completed capture moves state to stopped
// R05: stop command halts acquisition exactly like the front-panel stop key
// R06: mode held among normal, peak, average, enhanced resolution; reported back
// R07: enhanced resolution mode enables the boxcar smoothing filter output
// R08: enhanced resolution rejected unless the advanced engine variant is present
// R09: averaging count taken with mode command only when average is chosen
// R10: averaging count may be set alone and is reported back
// R11: single channel per converter offers 7K, 70K, 700K, 7M depths
// R12: interleaved converters offer 14K, 140K, 1.4M, 14M depths
// R13: point count derives from scale and depth, never written directly
// R14: point count reported for each of the four analog channels
// R15: interpolation select: on means sine, off means linear; readable
// R16: present acquisition state is reported
// R17: analog sample rate reported; logic channel rate where supported
// R18: mode or count change while averaging restarts the accumulation
module acqctl_core #(
  parameter bit ENH_ENGINE = 1'b1,
  parameter bit LOGIC_RATE_SUPPORTED = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire acqctl_pkg::acqctl_req_t req_i,
  input wire logic single_mode_i,
  input wire logic stop_key_i,
  input wire logic trigger_i,
  input wire logic capture_done_i,
  input wire logic interleave_i,
  input wire logic [acqctl_pkg::SCALE_W-1:0] scale_points_i,
  input wire logic [acqctl_pkg::CHAN_N-1:0] chan_on_i,
  input wire logic [acqctl_pkg::RATE_W-1:0] analog_rate_i,
  input wire logic [acqctl_pkg::RATE_W-1:0] logic_rate_i,
  output logic [$bits(acqctl_pkg::acqctl_rsp_t)-1:0] rsp_o,
  output logic [$bits(acqctl_pkg::acqctl_cfg_t)-1:0] cfg_o,
  output logic trig_enable_o,
  output logic smooth_enable_o,
  output logic avg_restart_o,
  output logic [acqctl_pkg::CHAN_N*acqctl_pkg::PTS_W-1:0] points_o,
  output logic [acqctl_pkg::RATE_W-1:0] analog_rate_o,
  output logic [acqctl_pkg::RATE_W-1:0] logic_rate_o,
  output logic logic_rate_valid_o
);

  typedef struct packed {
    acqctl_pkg::acqctl_rsp_t rsp;
    acqctl_pkg::acqctl_cfg_t cfg;
    logic [acqctl_pkg::STAT_W-1:0] status;
    logic trig_en;
    logic smooth;
    logic avg_restart;
    logic [acqctl_pkg::CHAN_N*acqctl_pkg::PTS_W-1:0] points;
    logic [acqctl_pkg::RATE_W-1:0] arate;
    logic [acqctl_pkg::RATE_W-1:0] lrate;
    logic lrate_ok;
    logic [2:0] stop_key_sync;
    logic [1:0] trig_sync;
    logic [1:0] done_sync;
    logic [1:0] single_sync;
    logic [1:0] ilv_sync;
  } acqctl_st_t;

  acqctl_st_t st_ff;
  acqctl_st_t nxt_st;
  logic [acqctl_pkg::DEPTH_W-1:0] depth_max;
  logic [acqctl_pkg::PTS_W-1:0] pts_one;

  // R11: non-interleaved depth table
  // R12: interleaved depth doubles the table
  always_comb
  begin
    unique case (st_ff.cfg.depth_sel)
      2'h0: depth_max = acqctl_pkg::DEPTH_BASE_0;
      2'h1: depth_max = acqctl_pkg::DEPTH_BASE_1;
      2'h2: depth_max = acqctl_pkg::DEPTH_BASE_2;
      2'h3: depth_max = acqctl_pkg::DEPTH_BASE_3;
    endcase
    if (st_ff.ilv_sync[1])
    begin
      depth_max = depth_max << 1;
    end
    // R13: points follow scale clipped to depth
    pts_one = (scale_points_i < depth_max) ? scale_points_i : depth_max;
  end

  function automatic logic avg_ok(input logic [3:0] l2);
    avg_ok = (l2 >= acqctl_pkg::AVG_LOG2_MIN) && (l2 <= acqctl_pkg::AVG_LOG2_MAX)
      && (l2 != acqctl_pkg::AVG_LOG2_SKIP);
  endfunction : avg_ok

  always_comb
  begin
    logic new_acq;
    logic stop_evt;
    new_acq = 1'b0;
    stop_evt = 1'b0;
    nxt_st = st_ff;
    nxt_st.rsp.done = 1'b0;
    nxt_st.rsp.reject = 1'b0;
    nxt_st.avg_restart = 1'b0;
    nxt_st.stop_key_sync = {st_ff.stop_key_sync[1:0], stop_key_i};
    nxt_st.trig_sync = {st_ff.trig_sync[0], trigger_i};
    nxt_st.done_sync = {st_ff.done_sync[0], capture_done_i};
    nxt_st.single_sync = {st_ff.single_sync[0], single_mode_i};
    nxt_st.ilv_sync = {st_ff.ilv_sync[0], interleave_i};

    // capture events from the acquisition engine
    if (st_ff.trig_sync[1] && st_ff.cfg.state == acqctl_pkg::STATE_ARMED)
    begin
      nxt_st.cfg.state = acqctl_pkg::STATE_TRIGGERED;
    end
    if (st_ff.done_sync[1] && st_ff.cfg.state != acqctl_pkg::STATE_STOPPED)
    begin
      new_acq = 1'b1;
      // R04: single capture ends in stopped
      if (st_ff.single_sync[1])
      begin
        nxt_st.cfg.state = acqctl_pkg::STATE_STOPPED;
        nxt_st.trig_en = 1'b0;
      end
      else
      begin
        nxt_st.cfg.state = acqctl_pkg::STATE_ARMED;
      end
    end
    // R05: front-panel stop key, rising edge
    if (st_ff.stop_key_sync[1] && !st_ff.stop_key_sync[2])
    begin
      stop_evt = 1'b1;
    end

    unique case (req_i.code)
      acqctl_pkg::CMD_ARM:
      begin
        // R01: re-arm the trigger
        nxt_st.cfg.state = acqctl_pkg::STATE_ARMED;
        nxt_st.trig_en = 1'b1;
        nxt_st.rsp.done = 1'b1;
      end
      acqctl_pkg::CMD_STOP:
      begin
        // R05: same path as the stop key
        stop_evt = 1'b1;
        nxt_st.rsp.done = 1'b1;
      end
      acqctl_pkg::CMD_SET_MODE:
      begin
        nxt_st.rsp.done = 1'b1;
        // R08: enhanced resolution only with advanced engine
        // R09: count only valid with average mode
        if ((req_i.mode == acqctl_pkg::MODE_ENH_RES && !ENH_ENGINE)
          || (req_i.mode == acqctl_pkg::MODE_AVERAGE && !avg_ok(req_i.avg_log2)))
        begin
          nxt_st.rsp.reject = 1'b1;
        end
        else
        begin
          // R06: hold the selected mode
          nxt_st.cfg.mode = req_i.mode;
          if (req_i.mode == acqctl_pkg::MODE_AVERAGE)
          begin
            nxt_st.cfg.avg_log2 = req_i.avg_log2;
          end
          // R18: restart averaging on change
          if (req_i.mode != st_ff.cfg.mode || (req_i.mode == acqctl_pkg::MODE_AVERAGE
            && req_i.avg_log2 != st_ff.cfg.avg_log2))
          begin
            nxt_st.avg_restart = 1'b1;
          end
        end
      end
      acqctl_pkg::CMD_SET_AVG:
      begin
        nxt_st.rsp.done = 1'b1;
        // R10: count set on its own
        if (!avg_ok(req_i.avg_log2))
        begin
          nxt_st.rsp.reject = 1'b1;
        end
        else
        begin
          nxt_st.cfg.avg_log2 = req_i.avg_log2;
          // R18: restart when averaging live
          if (st_ff.cfg.mode == acqctl_pkg::MODE_AVERAGE
            && req_i.avg_log2 != st_ff.cfg.avg_log2)
          begin
            nxt_st.avg_restart = 1'b1;
          end
        end
      end
      acqctl_pkg::CMD_SET_DEPTH:
      begin
        // R11: depth index stored
        nxt_st.cfg.depth_sel = req_i.depth_sel;
        nxt_st.rsp.done = 1'b1;
      end
      acqctl_pkg::CMD_SET_INTERP:
      begin
        // R15: sine when set, linear when clear
        nxt_st.cfg.interp_sine = req_i.interp_sine;
        nxt_st.rsp.done = 1'b1;
      end
      acqctl_pkg::CMD_READ_STATUS:
      begin
        // R03: return then clear
        nxt_st.rsp.status = st_ff.status;
        nxt_st.status = '0;
        nxt_st.rsp.done = 1'b1;
      end
      default:
      begin
        nxt_st.rsp.reject = (req_i.code != acqctl_pkg::CMD_NONE);
        nxt_st.rsp.done = (req_i.code != acqctl_pkg::CMD_NONE);
      end
    endcase

    if (stop_evt)
    begin
      nxt_st.cfg.state = acqctl_pkg::STATE_STOPPED;
      nxt_st.trig_en = 1'b0;
    end

    // R02: set wins over read clear
    if (new_acq)
    begin
      nxt_st.status[acqctl_pkg::STAT_NEW_ACQ_BIT] = 1'b1;
    end
    // capture taken while armed reports trigger-ready, also when single mode stops
    if (req_i.code == acqctl_pkg::CMD_ARM || (new_acq && st_ff.trig_en))
    begin
      nxt_st.status[acqctl_pkg::STAT_TRIG_RDY_BIT] = 1'b1;
    end

    // R07: boxcar smoothing only in enhanced resolution
    nxt_st.smooth = (nxt_st.cfg.mode == acqctl_pkg::MODE_ENH_RES);
    // R14: per-channel point counts
    for (int i = 0; i < acqctl_pkg::CHAN_N; i++)
    begin
      nxt_st.points[i*acqctl_pkg::PTS_W +: acqctl_pkg::PTS_W] =
        chan_on_i[i] ? pts_one : '0;
    end
    // R17: rate reports
    nxt_st.arate = analog_rate_i;
    nxt_st.lrate = LOGIC_RATE_SUPPORTED ? logic_rate_i : '0;
    nxt_st.lrate_ok = LOGIC_RATE_SUPPORTED;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_ff <= '0;
      st_ff.cfg.avg_log2 <= acqctl_pkg::AVG_LOG2_RST;
      st_ff.cfg.depth_sel <= acqctl_pkg::DEPTH_SEL_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rsp_o = st_ff.rsp;
  // R16: state reported with settings
  assign cfg_o = st_ff.cfg;
  assign trig_enable_o = st_ff.trig_en;
  assign smooth_enable_o = st_ff.smooth;
  assign avg_restart_o = st_ff.avg_restart;
  assign points_o = st_ff.points;
  assign analog_rate_o = st_ff.arate;
  assign logic_rate_o = st_ff.lrate;
  assign logic_rate_valid_o = st_ff.lrate_ok;

endmodule : acqctl_core

// ---- testbench/acqctl_sva.sv ----
// checker: acquisition control port assertions
`timescale 1ns/1ps
module acqctl_sva (
  input logic clk_sys_i,
  input logic rst_n_i,
  input acqctl_pkg::acqctl_req_t req_i,
  input logic capture_done_i,
  input logic [3:0] chan_on_i,
  input logic [31:0] analog_rate_i,
  input logic [17:0] rsp_o,
  input logic [10:0] cfg_o,
  input logic trig_enable_o,
  input logic avg_restart_o,
  input logic [99:0] points_o,
  input logic [31:0] analog_rate_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  a_cmd_answered: assert property (req_i.code != 4'h0 |=> rsp_o[17])
    else $error("command not answered");
  a_arm_starts: assert property (req_i.code == 4'h1 |=> trig_enable_o && cfg_o[1:0] == 2'h1)
    else $error("arm did not start capture");
  a_stop_halts: assert property (req_i.code == 4'h2 |=> !trig_enable_o && cfg_o[1:0] == 2'h0)
    else $error("stop did not halt");
  a_arm_status: assert property (req_i.code == 4'h1 ##1 req_i.code == 4'h7 |=> rsp_o[13])
    else $error("trigger ready bit missing");
  a_read_clears: assert property ((req_i.code == 4'h7 && !trig_enable_o) ##1
    (req_i.code == 4'h7 && !capture_done_i && !$past(capture_done_i)
    && !$past(capture_done_i, 2) && !$past(capture_done_i, 3)) |=> rsp_o[15:0] == 16'h0)
    else $error("status not cleared by read");
  a_mode_kept: assert property (req_i.code == 4'h3 && req_i.mode < 2'h2
    |=> cfg_o[10:9] == $past(req_i.mode))
    else $error("mode not taken");
  a_mode_restart: assert property (req_i.code == 4'h3 && req_i.mode != 2'h2
    && req_i.mode != cfg_o[10:9] |=> avg_restart_o)
    else $error("no averaging restart");
  a_avg_refused: assert property (req_i.code == 4'h4 && (req_i.avg_log2 < 4'h2
    || req_i.avg_log2 == 4'h3 || req_i.avg_log2 > 4'h9) |=> rsp_o[16] && $stable(cfg_o[8:5]))
    else $error("bad count accepted");
  a_off_points: assert property (!chan_on_i[0] && !$past(chan_on_i[0]) |-> points_o[24:0] == 25'h0)
    else $error("points of idle channel");
  a_rate_follows: assert property ($past(rst_n_i)
    |-> analog_rate_o == $past(analog_rate_i))
    else $error("rate not passed");
endmodule : acqctl_sva
bind acqctl_core acqctl_sva chk (.clk_sys_i, .rst_n_i, .req_i, .capture_done_i, .chan_on_i,
  .analog_rate_i, .rsp_o, .cfg_o, .trig_enable_o, .avg_restart_o, .points_o, .analog_rate_o);

// ---- testbench/acqctl_front.sv ----
// model: capture front end, trigger then capture when armed
`timescale 1ns/1ps
module acqctl_front (
  input logic clk_sys_i,
  input logic rst_n_i,
  input logic armed_i,
  input logic fire_i,
  output logic trigger_o,
  output logic capture_done_o
);
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trigger_o <= 1'b0;
      capture_done_o <= 1'b0;
    end
    else
    begin
      trigger_o <= fire_i && armed_i;
      capture_done_o <= trigger_o;
    end
  end
endmodule : acqctl_front

// ---- testbench/tb_acquisition_command_control.sv ----
// testbench: acquisition command control
`timescale 1ns/1ps
module tb_acquisition_command_control;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [12:0] req = '0;
  logic single = 1'b0, stop_key = 1'b0, il = 1'b0, fire = 1'b0, trig, cdone;
  logic [24:0] scale = '0, e;
  logic [3:0] chan_on = 4'hf, av, av_try;
  logic [31:0] arate = '0, lrate = '0, arate_o, lrate_o;
  logic [17:0] rsp;
  logic [10:0] cfg;
  logic trig_en, smooth, restart, lvalid;
  logic [99:0] points;
  logic [16:0] expq[$];
  logic [15:0] last_stat = '0;
  int num_errors = 0;
  int checked = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  acqctl_core uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req),
    .single_mode_i(single), .stop_key_i(stop_key), .trigger_i(trig), .capture_done_i(cdone),
    .interleave_i(il), .scale_points_i(scale), .chan_on_i(chan_on), .analog_rate_i(arate),
    .logic_rate_i(lrate), .rsp_o(rsp), .cfg_o(cfg), .trig_enable_o(trig_en),
    .smooth_enable_o(smooth), .avg_restart_o(restart), .points_o(points),
    .analog_rate_o(arate_o), .logic_rate_o(lrate_o), .logic_rate_valid_o(lvalid));
  acqctl_front front (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .armed_i(trig_en),
    .fire_i(fire), .trigger_o(trig), .capture_done_o(cdone));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // one command; expected answer noted for the monitor
  task automatic cmd(input logic [12:0] r, input logic rej, input logic [15:0] st);
    if (r[12:9] == 4'h7)
      last_stat = st;
    expq.push_back({rej, last_stat});
    req = r;
    @(posedge clk_sys_i);
    #1;
  endtask : cmd
  task automatic step(input int n);
    req = '0;
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  always @(negedge clk_sys_i)
    if (rsp[17] === 1'b1)
    begin
      if (expq.size() == 0)
        check(32'h1, 32'h0);
      else
        check(rsp[16:0], expq.pop_front());
    end
  initial
  begin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(10089));
    repeat (12) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    check(cfg, 11'h080);
    single = 1'b1;
    arate = $urandom();
    lrate = $urandom();
    scale = 25'h1ffffff;
    cmd({4'h1, 9'h0}, 1'b0, 16'h0);
    cmd({4'h7, 9'h0}, 1'b0, 16'h2000);
    cmd({4'h7, 9'h0}, 1'b0, 16'h0);
    check(cfg[1:0], 2'h1);
    fire = 1'b1;
    step(1);
    fire = 1'b0;
    step(8);
    check(cfg[1:0], 2'h0);
    check(trig_en, 1'b0);
    cmd({4'h7, 9'h0}, 1'b0, 16'h2001);
    cmd({4'h7, 9'h0}, 1'b0, 16'h0);
    cmd({4'h1, 9'h0}, 1'b0, 16'h0);
    stop_key = 1'b1;
    step(6);
    check(cfg[1:0], 2'h0);
    check(trig_en, 1'b0);
    stop_key = 1'b0;
    cmd({4'h1, 9'h0}, 1'b0, 16'h0);
    cmd({4'h2, 9'h0}, 1'b0, 16'h0);
    for (int m = 3; m >= 0; m--)
    begin
      av_try = 4'h4 + 4'($urandom_range(5));
      cmd({4'h3, m[1:0], av_try, 3'h0}, 1'b0, 16'h0);
      step(2);
      check(cfg[10:9], m[1:0]);
      check(smooth, m == 3);
      if (m == 2)
      begin
        av = av_try;
        check(cfg[8:5], av);
      end
    end
    cmd({4'h3, 2'h2, 4'h3, 3'h0}, 1'b1, 16'h0);
    step(2);
    check(cfg[10:9], 2'h0);
    check(cfg[8:5], av);
    for (int v = 0; v < 16; v++)
    begin
      cmd({4'h4, 2'h0, v[3:0], 3'h0}, !(v == 2 || (v >= 4 && v <= 9)), 16'h0);
      if (v == 2 || (v >= 4 && v <= 9))
        av = v[3:0];
      step(2);
      check(cfg[8:5], av);
    end
    for (int c = 8; c < 16; c++)
      cmd({c[3:0], 9'h0}, 1'b1, 16'h0);
    for (int k = 0; k < 8; k++)
    begin
      il = k[2];
      e = 25'h0001b58;
      repeat (k % 4) e = e * 10;
      cmd({4'h5, 6'h0, k[1:0], 1'b0}, 1'b0, 16'h0);
      step(4);
      if (il == 1'b0)
        check(points[24:0], e);
      else
        check(points[24:0], e * 2);
    end
    scale = 25'($urandom_range(6999));
    step(3);
    check(points[24:0], scale);
    chan_on = 4'he;
    step(3);
    check(points[24:0], 25'h0);
    check(points[49:25], scale);
    for (int i = 1; i >= 0; i--)
    begin
      cmd({4'h6, 8'h0, i[0]}, 1'b0, 16'h0);
      step(2);
      check(cfg[2], i[0]);
    end
    check(arate_o, arate);
    check(lrate_o, lrate);
    check(lvalid, 1'b1);
    rst_n_i = 1'b0;
    step(2);
    rst_n_i = 1'b1;
    check(cfg, 11'h080);
    check(points[49:25], 25'h0);
    step(3);
    check(points[49:25], scale);
    check(expq.size(), 0);
    give_verdict();
  end
endmodule : tb_acquisition_command_control
